// ===== parity_calc.sv
/*
  Parity generation and checking for 7- or 8-bit characters.
  Assumes data and mode are stable while the result is used.
*/
`timescale 1ns/1ns
module parity_calc import uart_pkg::*; (
  input  wire logic [7:0] data_i,
  input  wire logic       len8_i,
  input  parity_t         mode_i,
  input  wire logic       rx_bit_i,
  output logic            tx_bit_o,
  output logic            rx_err_o
);

  logic [7:0] used;
  logic       ones_odd;

  // Bit 7 takes no part in a 7-bit character
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_mask
      if (i == 7)
        assign used[i] = data_i[i] & len8_i;
      else
        assign used[i] = data_i[i];
    end
  endgenerate

  assign ones_odd = ^used;

  // Zero and no-parity modes never flag an error
  always_comb
  begin
    tx_bit_o = 1'b0;
    rx_err_o = 1'b0;
    case (mode_i)
      PAR_EVEN:
      begin
        tx_bit_o = ones_odd;                 // R4
        rx_err_o = ones_odd ^ rx_bit_i;      // R5
      end
      PAR_ODD:
      begin
        tx_bit_o = ~ones_odd;                // R6
        rx_err_o = ~(ones_odd ^ rx_bit_i);   // R7
      end
      PAR_ZERO:
      begin
        tx_bit_o = 1'b0;                     // R8
        rx_err_o = 1'b0;                     // R8
      end
      default:
      begin
        tx_bit_o = 1'b0;
        rx_err_o = 1'b0;
      end
    endcase
  end

endmodule

// ===== pin_sync.sv
/*
  Three-stage synchroniser for the serial input pin.
  Assumes the pin is asynchronous to clk_i; a change counts once the
  second and third stages agree, so one-clock glitches are dropped.
*/
`timescale 1ns/1ns
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage is read only by the second; idle line is high
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_o <= 1'b1;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_o <= s2_q;
    end
  end

endmodule

// ===== serial_node.sv
/*
  Remote serial node: drives the receive line and watches the transmit line.
  Assumes a bit time of bit_clks clocks and that the bench sets the divisor to match.
*/
`timescale 1ns/1ns
module serial_node (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  int bit_clks = 8;
  initial line_o = 1'b1;
  // Hold one level for n bit times
  task automatic drive(input logic v, input int n);
    line_o <= v;
    repeat (n * bit_clks) @(posedge clk_i);
  endtask
  // Frame LSB first; parity bit only when par is not negative
  task automatic send(input logic [7:0] d, input int par, input logic stop);
    @(posedge clk_i);
    drive(1'b0, 1);
    for (int i = 0; i < 8; i++) drive(d[i], 1);
    if (par >= 0) drive(par[0], 1);
    drive(stop, 1); // A low stop acts as a break cutting into the frame
    line_o <= 1'b1;
  endtask
  // Low for n bits, then idle high long enough to end it
  task automatic low(input int n);
    @(posedge clk_i);
    drive(1'b0, n);
    drive(1'b1, 2);
  endtask
  // Mid-bit samples of eleven bits from the falling start edge
  task automatic grab(output logic [10:0] bits);
    @(negedge line_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++)
    begin
      bits[i] = line_i;
      repeat (bit_clks) @(posedge clk_i);
    end
  endtask
  // Clocks of low level; bounded so a stuck line cannot hang the run
  task automatic width(output int n);
    n = 0;
    @(negedge line_i);
    while (line_i === 1'b0 && n < 4000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
endmodule

// ===== uart_params.svh
/*
  Register offsets, field positions, reset values and counts of the
  receive-error, parity and break block.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH

// Register offsets on the 3-bit address port
`define ADDR_CTL      3'h0
`define ADDR_OPT      3'h1
`define ADDR_BAUD     3'h2
`define ADDR_STS      3'h3
`define ADDR_TXD      3'h4
`define ADDR_RXD      3'h5

// Fields of control_register_main
`define CTL_PWR       7
`define CTL_TXE       6
`define CTL_RXE       5
`define CTL_PS_HI     3
`define CTL_PS_LO     2
`define CTL_CL8       1
`define CTL_SL2       0
`define CTL_RST       8'h00

// Fields of option_register
`define OPT_SRF       7
`define OPT_SRT       6
`define OPT_STT       5
`define OPT_SLS_HI    4
`define OPT_SLS_LO    2
`define OPT_SLS_RST   3'h0

// Baud divisor: one bit lasts twice this many clocks
`define BAUD_RST      8'hff

// Fields of receive_status_register
`define STS_TSF       7
`define STS_PE        2
`define STS_FE        1
`define STS_OVE       0

// Bit counts
`define DATA7_LAST    3'h6
`define DATA8_LAST    3'h7
`define BRK_TX_BASE   5'h0d
`define BRK_RX_MIN    5'h0b
`define BRK_CNT_MAX   5'h1f
`define RX_SHIFT_INIT 8'hff

`endif

// ===== uart_pkg.sv
/*
  Types shared by the receive-error, parity and break block.
  Assumes no surroundings beyond the compile order.
*/
package uart_pkg;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } parity_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h3,
    TX_STOP  = 3'h4,
    TX_BRK   = 3'h5
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4,
    RX_BRK   = 3'h5
  } rx_state_t;

endpackage

// ===== uart_rx_errors_parity_break.sv
/*
  Serial transceiver core: receive error flags, parity, sync break send
  and receive, behind a simple register port.
  Assumes a bus master that issues one-cycle strobes, never both at once,
  and reads data in the cycle after the read strobe.
*/
// Decided for this implementation: the register addresses and the address-and-strobe port.
// Function
// R1: Any receive error sets its status flag and raises the receive-complete interrupt.
// R2: Software reads status, then clears each error flag by writing zero.
// R3: Parity mismatch, missing stop bit, unread previous frame set PE, FE, OVE.
// R4: Even parity transmit: parity bit is one when data ones are odd.
// R5: Even parity receive: odd total of ones including parity is an error.
// R6: Odd parity transmit: parity bit is zero when data ones are odd.
// R7: Odd parity receive: even total of ones including parity is an error.
// R8: Zero parity sends a zero parity bit and never checks on receive.
// R9: No parity adds no bit and never raises a parity error.
// R10: Software keeps the parity select field at zero when using LIN.
// R11: Powered, enabled, break trigger drives the output low for 13 to 20 bits.
// R12: Every break transmission starts with a transmit-enable interrupt.
// R13: The break transmit trigger clears itself when the break ends.
// R14: After a break the transmitter idles until new data or a new trigger.
// R15: Break receive trigger enters break-wait, watching for a start bit.
// R16: After the start bit, a bit counter advances at the baud rate until stop.
// R17: Low width of eleven bits or more is valid: interrupt, flag cleared.
// R18: A valid break sets no error flags and performs no error checking.
// R19: A valid break leaves receive data untouched; the shift register keeps all ones.
// R20: Ten bits or fewer ends silently, back to break-wait, flag still set.
// R21: Software sets no break trigger while the break receive flag is one.
// R22: A break arriving during a data frame reports a framing error.
// R23: Overrun discards the new frame; parity or framing errors still load data.
// R24: The receiver checks one stop bit and ignores any second one.
`timescale 1ns/1ns
`include "uart_params.svh"
module uart_rx_errors_parity_break import uart_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  input  wire logic       serial_in_pin_i,
  output logic            serial_out_pin_o,
  output logic            rx_complete_irq_o,
  output logic            tx_enable_irq_o
);

  logic [7:0] ctl_q;
  logic [7:0] baud_q;
  logic [2:0] sls_q;
  logic       stt_q;
  logic       srf_q;
  logic [7:0] txd_q;
  logic       tx_pend_q;
  logic [7:0] rxd_q;
  logic       rx_full_q;
  logic       pe_q;
  logic       fe_q;
  logic       ove_q;
  tx_state_t  tx_st_q;
  logic [8:0] tx_tmr_q;
  logic [4:0] tx_cnt_q;
  logic [7:0] tx_dat_q;
  rx_state_t  rx_st_q;
  logic [8:0] rx_tmr_q;
  logic [2:0] rx_cnt_q;
  logic [4:0] low_cnt_q;
  logic [7:0] rsh_q;
  logic       rpar_q;
  logic       rx_prev_q;
  logic       rx_in;
  logic       tx_par_bit;
  logic       rx_par_err;
  parity_t    par_mode;
  logic       tx_en;
  logic       rx_en;
  logic       len8;
  logic [2:0] data_last;
  logic [8:0] full_end;
  logic [8:0] half_end;
  logic       tx_bit_end;
  logic       rx_samp;
  logic [4:0] brk_len;
  logic [7:0] rx_word;
  logic       rx_done;
  logic       brk_ok;
  logic       brk_bad;
  logic       ove_evt;
  logic       pe_evt;
  logic       fe_evt;

  // Configuration decode
  assign par_mode   = parity_t'(ctl_q[`CTL_PS_HI:`CTL_PS_LO]);
  assign tx_en      = ctl_q[`CTL_PWR] & ctl_q[`CTL_TXE];
  assign rx_en      = ctl_q[`CTL_PWR] & ctl_q[`CTL_RXE];
  assign len8       = ctl_q[`CTL_CL8];
  assign data_last  = len8 ? `DATA8_LAST : `DATA7_LAST;
  assign full_end   = {baud_q, 1'b0} - 9'h001;
  assign half_end   = {1'b0, baud_q} - 9'h001;
  assign brk_len    = `BRK_TX_BASE + {2'h0, sls_q};
  assign tx_bit_end = (tx_tmr_q == full_end);
  assign rx_samp    = (rx_tmr_q == full_end);
  assign rx_word    = len8 ? rsh_q : {1'b0, rsh_q[7:1]};

  pin_sync u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .pin_i   (serial_in_pin_i),
    .level_o (rx_in)
  );

  parity_calc u_tx_par (
    .data_i   (tx_dat_q),
    .len8_i   (len8),
    .mode_i   (par_mode),
    .rx_bit_i (1'b0),
    .tx_bit_o (tx_par_bit),
    .rx_err_o ()
  );

  parity_calc u_rx_par (
    .data_i   (rx_word),
    .len8_i   (len8),
    .mode_i   (par_mode),
    .rx_bit_i (rpar_q),
    .tx_bit_o (),
    .rx_err_o (rx_par_err)
  );

  // Receive events; the stop bit is sampled once and a second one ignored
  // Only a data frame reaches the stop state, so a break taken in break-wait never raises an error event
  assign rx_done = (rx_st_q == RX_STOP) && rx_samp;                        // R24 R18
  assign ove_evt = rx_done && rx_full_q;                                   // R3
  assign pe_evt  = rx_done && rx_par_err && (par_mode != PAR_NONE);        // R3 R9
  assign fe_evt  = rx_done && !rx_in;                                      // R3 R22
  assign brk_ok  = (rx_st_q == RX_BRK) && rx_samp && rx_in && (low_cnt_q >= `BRK_RX_MIN); // R17
  assign brk_bad = (rx_st_q == RX_BRK) && rx_samp && rx_in && (low_cnt_q < `BRK_RX_MIN);  // R20

  // Control, option and baud registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctl_q  <= `CTL_RST;
      baud_q <= `BAUD_RST;
      sls_q  <= `OPT_SLS_RST;
    end
    else if (we_i)
    begin
      if (addr_i == `ADDR_CTL)
        ctl_q <= wdata_i;
      if (addr_i == `ADDR_BAUD)
        baud_q <= wdata_i;
      if (addr_i == `ADDR_OPT)
        sls_q <= wdata_i[`OPT_SLS_HI:`OPT_SLS_LO];
    end
  end

  // Break triggers: set by software, cleared only by the hardware
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stt_q <= 1'b0;
      srf_q <= 1'b0;
    end
    else
    begin
      if (we_i && addr_i == `ADDR_OPT && wdata_i[`OPT_STT] && tx_en)
        stt_q <= 1'b1;                                                     // R11
      else if (tx_st_q == TX_BRK && tx_bit_end && tx_cnt_q == brk_len - 5'h01)
        stt_q <= 1'b0;                                                     // R13
      if (we_i && addr_i == `ADDR_OPT && wdata_i[`OPT_SRT] && rx_en)
        srf_q <= 1'b1;                                                     // R15
      else if (brk_ok)
        srf_q <= 1'b0;                                                     // R17
    end
  end

  // Transmit holding register; a new write wins over the hand-off
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      txd_q     <= 8'h00;
      tx_pend_q <= 1'b0;
    end
    else if (we_i && addr_i == `ADDR_TXD)
    begin
      txd_q     <= wdata_i;
      tx_pend_q <= 1'b1;
    end
    else if (tx_st_q == TX_IDLE && tx_en && !stt_q && tx_pend_q)
      tx_pend_q <= 1'b0;
  end

  // Transmit sequencer; a pending break goes before pending data
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_st_q         <= TX_IDLE;
      tx_tmr_q        <= 9'h000;
      tx_cnt_q        <= 5'h00;
      tx_dat_q        <= 8'h00;
      tx_enable_irq_o <= 1'b0;
    end
    else
    begin
      tx_enable_irq_o <= 1'b0;
      if (!tx_en)
        tx_st_q <= TX_IDLE;
      else
      begin
        case (tx_st_q)
          TX_IDLE:
          begin
            tx_tmr_q <= 9'h000;
            tx_cnt_q <= 5'h00;
            if (stt_q)
            begin
              tx_st_q         <= TX_BRK;                                   // R11
              tx_enable_irq_o <= 1'b1;                                     // R12
            end
            else if (tx_pend_q)
            begin
              tx_st_q         <= TX_START;                                 // R14
              tx_dat_q        <= txd_q;
              tx_enable_irq_o <= 1'b1;
            end
          end
          default:
          begin
            if (!tx_bit_end)
              tx_tmr_q <= tx_tmr_q + 9'h001;
            else
            begin
              tx_tmr_q <= 9'h000;
              tx_cnt_q <= tx_cnt_q + 5'h01;
              case (tx_st_q)
                TX_START:
                begin
                  tx_st_q  <= TX_DATA;
                  tx_cnt_q <= 5'h00;
                end
                TX_DATA:
                  if (tx_cnt_q[2:0] == data_last)
                  begin
                    tx_cnt_q <= 5'h00;
                    tx_st_q  <= (par_mode == PAR_NONE) ? TX_STOP : TX_PAR; // R9
                  end
                TX_PAR:
                begin
                  tx_st_q  <= TX_STOP;
                  tx_cnt_q <= 5'h00;
                end
                TX_STOP:
                  if (!ctl_q[`CTL_SL2] || tx_cnt_q != 5'h00)
                    tx_st_q <= TX_IDLE;
                TX_BRK:
                  if (tx_cnt_q == brk_len - 5'h01)
                    tx_st_q <= TX_IDLE;                                    // R14
                default:
                  tx_st_q <= TX_IDLE;
              endcase
            end
          end
        endcase
      end
    end
  end

  // Line driver, one clock behind the sequencer
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      serial_out_pin_o <= 1'b1;
    else
    begin
      case (tx_st_q)
        TX_START: serial_out_pin_o <= 1'b0;
        TX_DATA:  serial_out_pin_o <= tx_dat_q[tx_cnt_q[2:0]];
        TX_PAR:   serial_out_pin_o <= tx_par_bit;                          // R4 R6 R8
        TX_BRK:   serial_out_pin_o <= 1'b0;                                // R11
        default:  serial_out_pin_o <= 1'b1;
      endcase
    end
  end

  // Receive sequencer; mid-bit sampling from a half-bit start check
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_st_q   <= RX_IDLE;
      rx_tmr_q  <= 9'h000;
      rx_cnt_q  <= 3'h0;
      low_cnt_q <= 5'h00;
      rsh_q     <= `RX_SHIFT_INIT;
      rpar_q    <= 1'b0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= rx_in;
      if (!rx_en)
        rx_st_q <= RX_IDLE;
      else
      begin
        case (rx_st_q)
          RX_IDLE:
          begin
            rx_tmr_q <= 9'h000;
            if (rx_prev_q && !rx_in)
              rx_st_q <= RX_START;                                         // R15
          end
          RX_START:
            if (rx_tmr_q != half_end)
              rx_tmr_q <= rx_tmr_q + 9'h001;
            else
            begin
              rx_tmr_q  <= 9'h000;
              rx_cnt_q  <= 3'h0;
              low_cnt_q <= 5'h01;
              if (rx_in)
                rx_st_q <= RX_IDLE;
              else if (srf_q)
              begin
                rx_st_q <= RX_BRK;                                         // R16
                rsh_q   <= `RX_SHIFT_INIT;                                 // R19
              end
              else
                rx_st_q <= RX_DATA;
            end
          default:
            if (!rx_samp)
              rx_tmr_q <= rx_tmr_q + 9'h001;
            else
            begin
              rx_tmr_q <= 9'h000;
              case (rx_st_q)
                RX_DATA:
                begin
                  rsh_q    <= {rx_in, rsh_q[7:1]};
                  rx_cnt_q <= rx_cnt_q + 3'h1;
                  if (rx_cnt_q == data_last)
                    rx_st_q <= (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;  // R9
                end
                RX_PAR:
                begin
                  rpar_q  <= rx_in;
                  rx_st_q <= RX_STOP;
                end
                RX_BRK:
                  if (!rx_in)
                  begin
                    if (low_cnt_q != `BRK_CNT_MAX)
                      low_cnt_q <= low_cnt_q + 5'h01;                      // R16
                  end
                  else
                    rx_st_q <= RX_IDLE;                                    // R17 R20
                default:
                  rx_st_q <= RX_IDLE;                                      // R24
              endcase
            end
        endcase
      end
    end
  end

  // Receive data and full flag; a read that meets a new load stays full
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rxd_q     <= 8'h00;
      rx_full_q <= 1'b0;
    end
    else if (rx_done && !rx_full_q)
    begin
      rxd_q     <= rx_word;                                                // R23
      rx_full_q <= 1'b1;
    end
    else if (re_i && addr_i == `ADDR_RXD)
      rx_full_q <= 1'b0;
  end

  // Error flags: hardware set wins over a software zero write
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      ove_q <= 1'b0;
    end
    else
    begin
      if (pe_evt)
        pe_q <= 1'b1;                                                      // R1
      else if (we_i && addr_i == `ADDR_STS && !wdata_i[`STS_PE])
        pe_q <= 1'b0;                                                      // R2
      if (fe_evt)
        fe_q <= 1'b1;                                                      // R1
      else if (we_i && addr_i == `ADDR_STS && !wdata_i[`STS_FE])
        fe_q <= 1'b0;                                                      // R2
      if (ove_evt)
        ove_q <= 1'b1;                                                     // R1
      else if (we_i && addr_i == `ADDR_STS && !wdata_i[`STS_OVE])
        ove_q <= 1'b0;                                                     // R2
    end
  end

  // Receive-complete pulse; a short break stays silent
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_complete_irq_o <= 1'b0;
    else
      rx_complete_irq_o <= rx_done | brk_ok;                               // R1 R17 R20
  end

  // Read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (!re_i)
      rdata_o <= 8'h00;
    else
    begin
      case (addr_i)
        `ADDR_CTL:  rdata_o <= ctl_q;
        `ADDR_OPT:  rdata_o <= {srf_q, 1'b0, stt_q, sls_q, 2'h0};
        `ADDR_BAUD: rdata_o <= baud_q;
        `ADDR_STS:  rdata_o <= {tx_st_q != TX_IDLE, 4'h0, pe_q, fe_q, ove_q};
        `ADDR_RXD:  rdata_o <= rxd_q;
        default:    rdata_o <= 8'h00;
      endcase
    end
  end

  AST_ERR_IRQ: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
    (pe_evt || fe_evt || ove_evt) |=> rx_complete_irq_o)
    else $error("error without receive interrupt");

  AST_OVE_DISCARD: assert property (@(posedge clk_i) disable iff (!rstn_i) // R23
    ove_evt |=> ove_q && $stable(rxd_q))
    else $error("overrun frame was loaded");

  AST_PAR_QUIET: assert property (@(posedge clk_i) disable iff (!rstn_i) // R8
    (par_mode == PAR_ZERO || par_mode == PAR_NONE) && rx_done |-> !pe_evt)
    else $error("parity error in unchecked mode");

  AST_BRK_START: assert property (@(posedge clk_i) disable iff (!rstn_i) // R12
    (tx_st_q == TX_IDLE && tx_en && stt_q) |=> tx_enable_irq_o && tx_st_q == TX_BRK ##1 !serial_out_pin_o)
    else $error("break start without interrupt or low line");

  AST_STT_SELF_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i) // R13
    (tx_st_q == TX_BRK && tx_bit_end && tx_cnt_q == brk_len - 5'h01) |=> !stt_q && tx_st_q == TX_IDLE)
    else $error("break trigger not cleared at end");

  AST_BRK_VALID: assert property (@(posedge clk_i) disable iff (!rstn_i) // R17
    brk_ok |=> rx_complete_irq_o && !srf_q && $stable(rxd_q))
    else $error("valid break not completed");

  AST_BRK_SHORT: assert property (@(posedge clk_i) disable iff (!rstn_i) // R20
    brk_bad |=> !rx_complete_irq_o && srf_q && rx_st_q == RX_IDLE)
    else $error("short break mishandled");

  AST_BRK_NOERR: assert property (@(posedge clk_i) disable iff (!rstn_i) // R18
    (rx_st_q == RX_BRK && !(we_i && addr_i == `ADDR_STS)) |=> $stable({pe_q, fe_q, ove_q}))
    else $error("error flag event during break");

  AST_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
    (we_i && addr_i == `ADDR_STS && !wdata_i[`STS_FE] && !fe_evt) |=> !fe_q)
    else $error("framing flag not cleared by zero write");

  CV_FRAME: cover property (@(posedge clk_i) disable iff (!rstn_i) rx_done && !rx_full_q);
  CV_BRK_OK: cover property (@(posedge clk_i) disable iff (!rstn_i) brk_ok);
  CV_BRK_BAD: cover property (@(posedge clk_i) disable iff (!rstn_i) brk_bad);
  CV_BRK_TX: cover property (@(posedge clk_i) disable iff (!rstn_i) tx_st_q == TX_BRK && tx_bit_end);

endmodule

// ===== uart_rx_errors_parity_break_bench.sv
/*
  Self-checking bench: register access, parity, receive errors, sync breaks.
  Assumes the serial_node partner with a bit time of 8 clocks (divisor 4).
*/
`timescale 1ns/1ns
`include "uart_params.svh"
module uart_rx_errors_parity_break_bench;
  logic        clk_i = 1'b0, rstn_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00, rdata_o, d;
  logic        rx_line, tx_line, rx_irq, tx_irq;
  logic [10:0] bits;
  int          errors = 0, check_count = 0, rx_n = 0, tx_n = 0, n0, w;

  uart_rx_errors_parity_break dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line),
    .rx_complete_irq_o(rx_irq), .tx_enable_irq_o(tx_irq));
  serial_node node (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));

  // Clock of 50 ns
  always #25 clk_i = ~clk_i;
  // Interrupt pulses counted once per cycle
  always @(posedge clk_i)
  begin
    if (rx_irq === 1'b1) rx_n++;
    if (tx_irq === 1'b1) tx_n++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t mismatch seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  // Data is taken in the cycle after the strobe, once it has settled
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Covers sync delay and the interrupt pulse after a stop sample
  task automatic settle();
    repeat (16) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests need well under 10000 cycles
  initial
  begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`ADDR_CTL, d);
    check(d, 8'h00);
    rd(`ADDR_BAUD, d);
    check(d, 8'hff);
    rd(3'h7, d);
    check(d, 8'h00);
    wr(`ADDR_BAUD, 8'h04);
    $display("reset test done");
    // Mode m: 0 none, 1 zero, 2 odd, 3 even; 8'h07 holds an odd count of ones
    for (int m = 0; m < 4; m++)
    begin
      wr(`ADDR_CTL, 8'he2 | 8'(m << 2));
      fork
        node.grab(bits);
        wr(`ADDR_TXD, 8'h07);
      join
      check(bits[9:0], {m == 0 || m == 3, 8'h07, 1'b0});
      n0 = rx_n;
      node.send(8'h07, m == 0 ? -1 : (m == 1 ? 1 : 0), 1'b1);
      settle();
      check(rx_n, n0 + 1);
      rd(`ADDR_STS, d);
      check(d[2:0], {m == 3, 2'b00});
      rd(`ADDR_RXD, d);
      check(d, 8'h07);
      wr(`ADDR_STS, 8'h00);
      rd(`ADDR_STS, d);
      check(d[2:0], 3'h0);
    end
    $display("parity test done");
    wr(`ADDR_CTL, 8'he2); // Parity select held at zero for line work
    node.send(8'h5a, -1, 1'b0);
    settle();
    rd(`ADDR_STS, d);
    check(d[1:0], 2'b10);
    rd(`ADDR_RXD, d);
    check(d, 8'h5a);
    wr(`ADDR_STS, 8'h00);
    // Seven-bit odd parity: top bit of the sent byte lands in the parity slot
    wr(`ADDR_CTL, 8'he8);
    node.send(8'hb5, -1, 1'b1);
    settle();
    rd(`ADDR_STS, d);
    check(d[2:0], 3'h0);
    rd(`ADDR_RXD, d);
    check(d, 8'h35);
    // Two stop bits set, yet frames arrive with one stop each
    wr(`ADDR_CTL, 8'he3);
    node.send(8'h3c, -1, 1'b1);
    node.send(8'hc3, -1, 1'b1);
    settle();
    rd(`ADDR_STS, d);
    check(d[1:0], 2'b01);
    rd(`ADDR_RXD, d);
    check(d, 8'h3c);
    wr(`ADDR_STS, 8'h00);
    $display("error test done");
    for (int s = 0; s < 8; s += 7)
    begin
      n0 = tx_n;
      fork
        node.width(w);
        wr(`ADDR_OPT, 8'h20 | 8'(s << 2)); // Break receive flag is clear here
      join
      check(w, (13 + s) * 8);
      check(tx_n, n0 + 1);
      rd(`ADDR_OPT, d);
      check(d[5], 1'b0);
      settle();
      check(tx_line, 1'b1);
    end
    $display("break send test done");
    wr(`ADDR_OPT, 8'h40);
    rd(`ADDR_OPT, d);
    check(d[7], 1'b1);
    n0 = rx_n;
    node.low(10);
    settle();
    check(rx_n, n0);
    rd(`ADDR_OPT, d);
    check(d[7], 1'b1);
    node.low(11);
    settle();
    check(rx_n, n0 + 1);
    rd(`ADDR_OPT, d);
    check(d[7], 1'b0);
    rd(`ADDR_STS, d);
    check(d[2:0], 3'h0);
    rd(`ADDR_RXD, d);
    check(d, 8'h3c);
    $display("break receive test done");
    wrap_up();
  end
endmodule
